// *** verilog/led_pwm_pkg.sv ***
// Function
// - Short-status bit is 1 when output shorted.
// - Trip-point code picks 140/120/100/90 degrees.
// - Roll-off code scales current 100/75/55/30 percent.
// - Temperature flag set when die exceeds trip.
// - DC bit clear: duty registers drive outputs.
// - DC bit set: outputs held on, current-only.
// - DC bit 0 governs outputs 1 to 12.
// - DC bit 1 governs outputs 13 to 18.
// - Spread enable bit turns frequency spreading on.
// - Range and cycle codes pick spread and sweep.
// - Zero written to reset register restores defaults, unless shut down.
// - Eighteen channels, 256 to 65536 duty steps.
// - Reset default: 8-bit, 16MHz, 62kHz PWM.
// - Oscillator and resolution fields set PWM frequency.
// - Per-output 8-bit current scaling register.
// - Duty values take effect on update write, unless shut down.
// - Duty is two bytes; 8-bit uses low.
// - Software shutdown stops currents, keeps registers.
`default_nettype none
package led_pwm_pkg;
	localparam int           CLK_MHZ          = 250;
	localparam int           NUM_CH           = 18;
	localparam logic [7:0]   ADDR_CTRL        = 8'h00;
	localparam logic [7:0]   ADDR_PWM_FIRST   = 8'h01;
	localparam logic [7:0]   ADDR_PWM_LAST    = 8'h24;
	localparam logic [7:0]   ADDR_UPDATE      = 8'h49;
	localparam logic [7:0]   ADDR_SCALE_FIRST = 8'h4A;
	localparam logic [7:0]   ADDR_SCALE_LAST  = 8'h5B;
	localparam logic [7:0]   ADDR_GLOBAL      = 8'h6E;
	localparam logic [7:0]   ADDR_SHORT_LO    = 8'h72;
	localparam logic [7:0]   ADDR_SHORT_MID   = 8'h73;
	localparam logic [7:0]   ADDR_SHORT_HI    = 8'h74;
	localparam logic [7:0]   ADDR_THERMAL     = 8'h77;
	localparam logic [7:0]   ADDR_SPREAD      = 8'h78;
	localparam logic [7:0]   ADDR_RESET       = 8'h7F;
	localparam logic [7:0]   UPDATE_KEY       = 8'h00;
	localparam logic [7:0]   RESET_KEY        = 8'h00;
	localparam logic [7:0]   REG_DEFAULT      = 8'h00;
	localparam int           CTRL_SSD_BIT     = 0;
	localparam int           CTRL_RES_LSB     = 1;
	localparam int           CTRL_OSC_LSB     = 4;
	localparam int           TH_TS_LSB        = 0;
	localparam int           TH_FLAG_BIT      = 4;
	localparam int           TH_ROF_LSB       = 6;
	localparam logic [7:0]   TH_WRITE_MASK    = 8'hC3;
	localparam int           SS_CLT_LSB       = 0;
	localparam int           SS_RNG_LSB       = 2;
	localparam int           SS_EN_BIT        = 4;
	localparam int           SS_DC_LSB        = 5;
	localparam logic [7:0]   TRIP_C [4]       = '{8'h8C, 8'h78, 8'h64, 8'h5A};
	localparam logic [7:0]   ROLLOFF_X128 [4] = '{8'h80, 8'h60, 8'h46, 8'h26};
	localparam logic [5:0]   RANGE_X128 [4]   = '{6'h06, 6'h13, 6'h1F, 6'h2C};
	localparam int           SWEEP_US [4]     = '{1980, 1200, 820, 660};
	localparam int           TRI_STEPS        = 512;
	localparam longint       OSC_KHZ [8]      = '{16000, 8000, 1000, 500, 250, 125, 62, 31};
	localparam logic [15:0]  RES_MASK [4]     = '{16'h00FF, 16'h03FF, 16'h0FFF, 16'hFFFF};
	localparam int           ACC_W            = 24;
	function automatic logic [ACC_W-1:0] osc_inc(input logic [2:0] sel);
		osc_inc = ACC_W'((OSC_KHZ[sel] << ACC_W) / (longint'(CLK_MHZ) * 1000));
	endfunction : osc_inc
endpackage : led_pwm_pkg
`default_nettype wire

// *** verilog/led_pwm_thermal_spread_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module led_pwm_thermal_spread_ctrl #(
	parameter int SWEEP_CYCLES_0 = led_pwm_pkg::SWEEP_US[0] * led_pwm_pkg::CLK_MHZ,
	parameter int SWEEP_CYCLES_1 = led_pwm_pkg::SWEEP_US[1] * led_pwm_pkg::CLK_MHZ,
	parameter int SWEEP_CYCLES_2 = led_pwm_pkg::SWEEP_US[2] * led_pwm_pkg::CLK_MHZ,
	parameter int SWEEP_CYCLES_3 = led_pwm_pkg::SWEEP_US[3] * led_pwm_pkg::CLK_MHZ
) (
	input  wire logic          i_clk,
	input  wire logic          i_rst,
	input  wire logic          i_wr_en,
	input  wire logic          i_rd_en,
	input  wire logic [7:0]    i_addr,
	input  wire logic [7:0]    i_wr_data,
	input  wire logic          i_hw_shutdown_pin,
	input  wire logic [7:0]    i_die_temp,
	input  wire logic [17:0]   i_short_detect,
	output logic      [7:0]    o_rd_data,
	output logic      [17:0]   o_chan_on,
	output logic      [143:0]  o_chan_level
);
	localparam int N = led_pwm_pkg::NUM_CH;

	if (SWEEP_CYCLES_0 < led_pwm_pkg::TRI_STEPS || SWEEP_CYCLES_1 < led_pwm_pkg::TRI_STEPS ||
		SWEEP_CYCLES_2 < led_pwm_pkg::TRI_STEPS || SWEEP_CYCLES_3 < led_pwm_pkg::TRI_STEPS ||
		SWEEP_CYCLES_0 / led_pwm_pkg::TRI_STEPS >= (1 << 20))
	begin : g_bad_sweep
		$error("Sweep cycle counts out of range.");
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	// Register file.
	logic [7:0] ctrl, next_ctrl, global_current_level, next_gcc, thermal_cfg, next_thermal_cfg, spread_cfg, next_spread_cfg;
	logic [7:0] pwm_stage [2*N];
	logic [7:0] next_pwm_stage [2*N];
	logic [7:0] pwm_live [2*N];
	logic [7:0] next_pwm_live [2*N];
	logic [7:0] scale [N];
	logic [7:0] next_scale [N];
	logic       run_en, upd_fire, soft_rst_fire;
	logic [7:0] pwm_idx, scale_idx;

	assign pwm_idx   = 8'(i_addr - led_pwm_pkg::ADDR_PWM_FIRST);
	assign scale_idx = 8'(i_addr - led_pwm_pkg::ADDR_SCALE_FIRST);

	always_comb
	begin
		upd_fire      = i_wr_en && i_addr == led_pwm_pkg::ADDR_UPDATE && i_wr_data == led_pwm_pkg::UPDATE_KEY
			&& run_en;
		soft_rst_fire = i_wr_en && i_addr == led_pwm_pkg::ADDR_RESET && i_wr_data == led_pwm_pkg::RESET_KEY
			&& run_en;
		next_ctrl        = ctrl;
		next_gcc         = global_current_level;
		next_thermal_cfg = thermal_cfg;
		next_spread_cfg  = spread_cfg;
		next_pwm_stage   = pwm_stage;
		next_pwm_live    = pwm_live;
		next_scale       = scale;
		if (i_wr_en)
		begin
			if (i_addr == led_pwm_pkg::ADDR_CTRL)
				next_ctrl = i_wr_data;
			if (i_addr == led_pwm_pkg::ADDR_GLOBAL)
				next_gcc = i_wr_data;
			if (i_addr == led_pwm_pkg::ADDR_THERMAL)
				next_thermal_cfg = i_wr_data & led_pwm_pkg::TH_WRITE_MASK;
			if (i_addr == led_pwm_pkg::ADDR_SPREAD)
				next_spread_cfg = i_wr_data;
			if (i_addr >= led_pwm_pkg::ADDR_PWM_FIRST && i_addr <= led_pwm_pkg::ADDR_PWM_LAST)
				next_pwm_stage[pwm_idx[5:0]] = i_wr_data;
			if (i_addr >= led_pwm_pkg::ADDR_SCALE_FIRST && i_addr <= led_pwm_pkg::ADDR_SCALE_LAST)
				next_scale[scale_idx[4:0]] = i_wr_data;
		end
		if (upd_fire)
			next_pwm_live = pwm_stage;
		if (soft_rst_fire)
		begin
			next_ctrl        = led_pwm_pkg::REG_DEFAULT;
			next_gcc         = led_pwm_pkg::REG_DEFAULT;
			next_thermal_cfg = led_pwm_pkg::REG_DEFAULT;
			next_spread_cfg  = led_pwm_pkg::REG_DEFAULT;
			for (int i = 0; i < 2*N; i++)
			begin
				next_pwm_stage[i] = led_pwm_pkg::REG_DEFAULT;
				next_pwm_live[i]  = led_pwm_pkg::REG_DEFAULT;
			end
			for (int i = 0; i < N; i++)
				next_scale[i] = led_pwm_pkg::REG_DEFAULT;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			ctrl        <= led_pwm_pkg::REG_DEFAULT;
			global_current_level         <= led_pwm_pkg::REG_DEFAULT;
			thermal_cfg <= led_pwm_pkg::REG_DEFAULT;
			spread_cfg  <= led_pwm_pkg::REG_DEFAULT;
			for (int i = 0; i < 2*N; i++)
			begin
				pwm_stage[i] <= led_pwm_pkg::REG_DEFAULT;
				pwm_live[i]  <= led_pwm_pkg::REG_DEFAULT;
			end
			for (int i = 0; i < N; i++)
				scale[i] <= led_pwm_pkg::REG_DEFAULT;
		end
		else
		begin
			ctrl        <= next_ctrl;
			global_current_level         <= next_gcc;
			thermal_cfg <= next_thermal_cfg;
			spread_cfg  <= next_spread_cfg;
			pwm_stage   <= next_pwm_stage;
			pwm_live    <= next_pwm_live;
			scale       <= next_scale;
		end
	end

	// Three-stage synchronisers; a change is taken once stages two and three agree.
	logic [26:0] sync1, sync2, sync3, filt, next_filt;
	logic        hw_pin_high, th_flag;
	logic [7:0]  temp_now;
	logic [17:0] short_now;

	always_comb
	begin
		next_filt = filt;
		for (int b = 0; b < 27; b++)
			if (sync2[b] == sync3[b])
				next_filt[b] = sync3[b];
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			sync1 <= 27'h0000000;
			sync2 <= 27'h0000000;
			sync3 <= 27'h0000000;
			filt  <= 27'h0000000;
		end
		else
		begin
			sync1 <= {i_hw_shutdown_pin, i_die_temp, i_short_detect};
			sync2 <= sync1;
			sync3 <= sync2;
			filt  <= next_filt;
		end
	end

	assign hw_pin_high = filt[26];
	assign temp_now    = filt[25:18];
	assign short_now   = filt[17:0];
	assign run_en      = hw_pin_high && ctrl[led_pwm_pkg::CTRL_SSD_BIT];
	assign th_flag     = temp_now > led_pwm_pkg::TRIP_C[thermal_cfg[led_pwm_pkg::TH_TS_LSB +: 2]];

	// Oscillator tick by phase accumulator, with triangle spreading.
	logic [led_pwm_pkg::ACC_W:0]   acc, next_acc;
	logic signed [7:0]             tri_val, next_tri_val;
	logic                          tri_up, next_tri_up;
	logic [19:0]                   step_cnt, next_step_cnt, step_len;
	logic [led_pwm_pkg::ACC_W-1:0] inc_base, inc_mod;
	logic signed [47:0]            spread_ofs;
	logic                          osc_tick;

	always_comb
	begin
		inc_base = led_pwm_pkg::osc_inc(ctrl[led_pwm_pkg::CTRL_OSC_LSB +: 3]);
		case (spread_cfg[led_pwm_pkg::SS_CLT_LSB +: 2])
			2'h0:    step_len = 20'(SWEEP_CYCLES_0 / led_pwm_pkg::TRI_STEPS);
			2'h1:    step_len = 20'(SWEEP_CYCLES_1 / led_pwm_pkg::TRI_STEPS);
			2'h2:    step_len = 20'(SWEEP_CYCLES_2 / led_pwm_pkg::TRI_STEPS);
			default: step_len = 20'(SWEEP_CYCLES_3 / led_pwm_pkg::TRI_STEPS);
		endcase
		spread_ofs = (signed'({24'h000000, inc_base})
			* signed'({42'h00000000000, led_pwm_pkg::RANGE_X128[spread_cfg[led_pwm_pkg::SS_RNG_LSB +: 2]]})
			* 48'(tri_val)) >>> 14;
		if (spread_cfg[led_pwm_pkg::SS_EN_BIT])
			inc_mod = led_pwm_pkg::ACC_W'(48'(signed'({24'h000000, inc_base})) + spread_ofs);
		else
			inc_mod = inc_base;
		next_acc      = {1'b0, acc[led_pwm_pkg::ACC_W-1:0]} + {1'b0, inc_mod};
		next_step_cnt = step_cnt + 20'h00001;
		next_tri_val  = tri_val;
		next_tri_up   = tri_up;
		if (step_cnt >= step_len - 20'h00001)
		begin
			next_step_cnt = 20'h00000;
			if (tri_up)
			begin
				next_tri_val = tri_val + 8'sh01;
				next_tri_up  = tri_val != 8'sh7E;
			end
			else
			begin
				next_tri_val = tri_val - 8'sh01;
				next_tri_up  = tri_val == 8'sh81;
			end
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			acc      <= '0;
			tri_val  <= 8'sh00;
			tri_up   <= 1'b1;
			step_cnt <= 20'h00000;
		end
		else
		begin
			acc      <= next_acc;
			tri_val  <= next_tri_val;
			tri_up   <= next_tri_up;
			step_cnt <= next_step_cnt;
		end
	end

	assign osc_tick = acc[led_pwm_pkg::ACC_W];

	// PWM period counter at the selected resolution.
	logic [15:0] pwm_cnt, next_pwm_cnt, res_mask;

	always_comb
	begin
		res_mask     = led_pwm_pkg::RES_MASK[ctrl[led_pwm_pkg::CTRL_RES_LSB +: 2]];
		next_pwm_cnt = pwm_cnt;
		if (osc_tick)
			next_pwm_cnt = ((pwm_cnt & res_mask) == res_mask) ? 16'h0000 : ((pwm_cnt + 16'h0001) & res_mask);
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			pwm_cnt <= 16'h0000;
		else
			pwm_cnt <= next_pwm_cnt;
	end

	// Per-channel gate and current level.
	logic [17:0]  next_chan_on;
	logic [143:0] next_chan_level;
	logic [15:0]  duty [N];
	logic [15:0]  base_lvl [N];
	logic [14:0]  roll_lvl [N];
	logic [7:0]   roll_factor;

	assign roll_factor = th_flag ? led_pwm_pkg::ROLLOFF_X128[thermal_cfg[led_pwm_pkg::TH_ROF_LSB +: 2]]
		: led_pwm_pkg::ROLLOFF_X128[0];

	for (genvar c = 0; c < N; c++)
	begin : g_chan
		logic dc_mode;
		assign dc_mode     = (c < 12) ? spread_cfg[led_pwm_pkg::SS_DC_LSB] : spread_cfg[led_pwm_pkg::SS_DC_LSB+1];
		assign duty[c]     = {pwm_live[2*c+1], pwm_live[2*c]} & res_mask;
		assign base_lvl[c] = global_current_level * scale[c];
		assign roll_lvl[c] = base_lvl[c][15:8] * roll_factor[6:0] + (roll_factor[7] ? {base_lvl[c][15:8], 7'h00} : 15'h0000);
		assign next_chan_on[c] = run_en && (dc_mode || duty[c] > pwm_cnt);
		assign next_chan_level[8*c +: 8] = run_en ? roll_lvl[c][14:7] : 8'h00;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			o_chan_on    <= '0;
			o_chan_level <= '0;
		end
		else
		begin
			o_chan_on    <= next_chan_on;
			o_chan_level <= next_chan_level;
		end
	end

	// Read port: data one cycle after the read strobe.
	logic [7:0] next_rd_data;

	always_comb
	begin
		next_rd_data = 8'h00;
		if (i_rd_en)
		begin
			case (i_addr)
				led_pwm_pkg::ADDR_CTRL:      next_rd_data = ctrl;
				led_pwm_pkg::ADDR_GLOBAL:    next_rd_data = global_current_level;
				led_pwm_pkg::ADDR_SPREAD:    next_rd_data = spread_cfg;
				led_pwm_pkg::ADDR_SHORT_LO:  next_rd_data = short_now[7:0];
				led_pwm_pkg::ADDR_SHORT_MID: next_rd_data = short_now[15:8];
				led_pwm_pkg::ADDR_SHORT_HI:  next_rd_data = {6'h00, short_now[17:16]};
				led_pwm_pkg::ADDR_THERMAL:   next_rd_data = (thermal_cfg & led_pwm_pkg::TH_WRITE_MASK)
					| {3'h0, th_flag, 4'h0};
				default:
				begin
					if (i_addr >= led_pwm_pkg::ADDR_PWM_FIRST && i_addr <= led_pwm_pkg::ADDR_PWM_LAST)
						next_rd_data = pwm_stage[pwm_idx[5:0]];
					else if (i_addr >= led_pwm_pkg::ADDR_SCALE_FIRST && i_addr <= led_pwm_pkg::ADDR_SCALE_LAST)
						next_rd_data = scale[scale_idx[4:0]];
				end
			endcase
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			o_rd_data <= 8'h00;
		else
			o_rd_data <= next_rd_data;
	end

	AST_SHORT_READ: assert property ((i_rd_en && i_addr == led_pwm_pkg::ADDR_SHORT_LO)
		|=> o_rd_data == $past(filt[7:0])) else $error("Short status read mismatch.");
	AST_ROLLOFF_30: assert property ((run_en && th_flag && thermal_cfg[7:6] == 2'h3 && global_current_level == 8'hFF
		&& scale[0] == 8'hFF) |=> o_chan_level[7:0] == 8'h4B) else $error("Roll-off level wrong.");
	AST_FLAG_READ: assert property ((i_rd_en && i_addr == led_pwm_pkg::ADDR_THERMAL)
		|=> o_rd_data[4] == $past(temp_now > led_pwm_pkg::TRIP_C[thermal_cfg[1:0]])) else $error("Flag read wrong.");
	AST_DUTY_ZERO_OFF: assert property ((run_en && !spread_cfg[5] && duty[0] == 16'h0000)
		|=> !o_chan_on[0]) else $error("Zero duty drove output.");
	AST_DC_LOW_GROUP: assert property ((run_en && spread_cfg[5]) |=> o_chan_on[11:0] == 12'hFFF)
		else $error("DC group one not held on.");
	AST_DC_HIGH_GROUP: assert property ((run_en && spread_cfg[6]) |=> o_chan_on[17:12] == 6'h3F)
		else $error("DC group two not held on.");
	AST_SOFT_RESET: assert property (soft_rst_fire |=> (ctrl == 8'h00 && spread_cfg == 8'h00
		&& thermal_cfg == 8'h00 && global_current_level == 8'h00)) else $error("Soft reset left a register set.");
	AST_UPDATE_ONLY: assert property ((!upd_fire && !soft_rst_fire) |=> $stable(pwm_live[0]))
		else $error("Live duty changed without update.");
	AST_SHUTDOWN_DARK: assert property ((!run_en) [*2] |-> (o_chan_on == 18'h00000
		&& o_chan_level == 144'h0)) else $error("Output active in shutdown.");
	AST_THERMAL_ZEROS: assert property ((i_rd_en && i_addr == led_pwm_pkg::ADDR_THERMAL)
		|=> (o_rd_data[5] == 1'b0 && o_rd_data[3:2] == 2'h0)) else $error("Unused thermal bits not zero.");
	AST_SCALE_IMMEDIATE: assert property ((i_wr_en && i_addr == led_pwm_pkg::ADDR_SCALE_FIRST
		&& !soft_rst_fire) |=> scale[0] == $past(i_wr_data)) else $error("Scale write not immediate.");
endmodule : led_pwm_thermal_spread_ctrl
`default_nettype wire

// *** sim/led_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module led_host_model (
	input  wire logic       i_clk,
	output logic            o_wr_en,
	output logic            o_rd_en,
	output logic      [7:0] o_addr,
	output logic      [7:0] o_wr_data,
	input  wire logic [7:0] i_rd_data
);
	initial
	begin
		o_wr_en   = 1'b0;
		o_rd_en   = 1'b0;
		o_addr    = 8'h00;
		o_wr_data = 8'h00;
	end
	// Released address and data lines show the inverse of the last value.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		o_wr_en   <= 1'b1;
		o_addr    <= a;
		o_wr_data <= d;
		@(posedge i_clk);
		o_wr_en   <= 1'b0;
		o_addr    <= ~a;
		o_wr_data <= ~d;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_clk);
		o_rd_en <= 1'b1;
		o_addr  <= a;
		@(posedge i_clk);
		o_rd_en <= 1'b0;
		o_addr  <= ~a;
		#1;
		d = i_rd_data;
	endtask : rd
	// Both thermal fields are written again, with unused bits set, before each read.
	task automatic rd_thermal(input logic [1:0] rof, input logic [1:0] ts, output logic [7:0] d);
		wr(8'h77, {rof, 4'hF, ts});
		rd(8'h77, d);
	endtask : rd_thermal
endmodule : led_host_model
`default_nettype wire

// *** sim/test_led_pwm_thermal_spread_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_led_pwm_thermal_spread_ctrl;
	logic         clk;
	logic         rst;
	logic         wr_en;
	logic         rd_en;
	logic [7:0]   addr;
	logic [7:0]   wr_data;
	logic         pin;
	logic [7:0]   die;
	logic [17:0]  shrt;
	logic [7:0]   rd_data;
	logic [17:0]  chan_on;
	logic [143:0] level;
	logic [7:0]   rv;
	logic [7:0]   r1;
	logic [7:0]   r2;
	logic [7:0]   sl;
	logic [7:0]   d;
	logic [1:0]   rof;
	int           num_errors = 0;
	int           n_compared = 0;
	int           seed       = 32'h97FD20C2;
	int           cnt;
	int           e;
	int           prev;
	led_pwm_thermal_spread_ctrl #(.SWEEP_CYCLES_0(1024), .SWEEP_CYCLES_1(1024),
		.SWEEP_CYCLES_2(1024), .SWEEP_CYCLES_3(1024)) i_dut (.i_clk(clk), .i_rst(rst),
		.i_wr_en(wr_en), .i_rd_en(rd_en), .i_addr(addr), .i_wr_data(wr_data),
		.i_hw_shutdown_pin(pin), .i_die_temp(die), .i_short_detect(shrt),
		.o_rd_data(rd_data), .o_chan_on(chan_on), .o_chan_level(level));
	led_host_model i_host (.i_clk(clk), .o_wr_en(wr_en), .o_rd_en(rd_en), .o_addr(addr),
		.o_wr_data(wr_data), .i_rd_data(rd_data));
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic check(input logic [143:0] seen, input logic [143:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("ERROR %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check
	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : print_verdict
	function automatic int trip(input int c);
		return (c == 0) ? 140 : (c == 1) ? 120 : (c == 2) ? 100 : 90;
	endfunction : trip
	function automatic logic [7:0] fac(input logic [1:0] c);
		return (c == 2'h0) ? 8'h80 : (c == 2'h1) ? 8'h60 : (c == 2'h2) ? 8'h46 : 8'h26;
	endfunction : fac
	function automatic logic [7:0] lvl(input logic [7:0] s, input logic [7:0] f);
		logic [15:0] p;
		p = (16'hFF * 16'(s)) >> 8;
		return 8'((p * 16'(f)) >> 7);
	endfunction : lvl
	task automatic measure(input int n);
		cnt = 0;
		repeat (n)
		begin
			@(posedge clk);
			#1;
			cnt += (chan_on[0] === 1'b1) ? 1 : 0;
		end
	endtask : measure
	initial
	begin
		#360000;
		num_errors++;
		$display("ERROR %0t timeout", $time);
		print_verdict();
	end
	initial
	begin
		rst  = 1'b1;
		pin  = 1'b0;
		die  = 8'h19;
		shrt = 18'h00000;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		check(chan_on, 0);
		check(level, 0);
		i_host.rd(8'h00, rv);
		check(rv, 0);
		i_host.rd(8'h77, rv);
		check(rv, 0);
		i_host.rd(8'h78, rv);
		check(rv, 0);
		$display("test reset done");
		pin <= 1'b1;
		sl = 8'($random(seed));
		i_host.wr(8'h6E, 8'hFF);
		i_host.wr(8'h4A, sl);
		i_host.wr(8'h00, 8'h01);
		for (int m = 1; m < 4; m++)
		begin
			i_host.wr(8'h78, 8'(m << 5));
			repeat (10) @(posedge clk);
			#1;
			check(chan_on, {(m[1] ? 6'h3F : 6'h00), (m[0] ? 12'hFFF : 12'h000)});
			check(level[15:0], {8'h00, lvl(sl, 8'h80)});
		end
		$display("test dc mode done");
		for (int t = 0; t < 4; t++)
		begin
			rof = 2'($random(seed));
			die <= 8'(trip(t) + 1);
			repeat (10) @(posedge clk);
			i_host.rd_thermal(rof, 2'(t), rv);
			check(rv, {rof, 4'h4, 2'(t)});
			check(level[7:0], lvl(sl, fac(rof)));
			die <= 8'(trip(t));
			repeat (10) @(posedge clk);
			i_host.rd_thermal(rof, 2'(t), rv);
			check(rv, {rof, 4'h0, 2'(t)});
			check(level[7:0], lvl(sl, 8'h80));
		end
		i_host.wr(8'h4A, 8'hFF);
		die <= 8'hC8;
		repeat (10) @(posedge clk);
		i_host.rd_thermal(2'h3, 2'h0, rv);
		check(rv, 8'hD0);
		check(level[7:0], lvl(8'hFF, fac(2'h3)));
		i_host.wr(8'h4A, sl);
		die <= 8'h19;
		$display("test thermal done");
		repeat (4)
		begin
			d = 8'($random(seed));
			i_host.wr(8'h78, d);
			i_host.rd(8'h78, rv);
			check(rv, d);
		end
		i_host.wr(8'h78, 8'h00);
		shrt <= 18'($random(seed));
		repeat (10) @(posedge clk);
		i_host.rd(8'h72, r1);
		i_host.rd(8'h73, r2);
		i_host.rd(8'h74, rv);
		check({rv, r2, r1}, {6'h00, shrt});
		$display("test spread and short done");
		prev = 0;
		for (int osc = 0; osc < 2; osc++)
		begin
			for (int k = 0; k < 2; k++)
			begin
				d = (k == 0) ? 8'hFF : 8'($random(seed));
				i_host.wr(8'h00, {1'b0, 3'(osc), 4'h1});
				i_host.wr(8'h01, d);
				i_host.wr(8'h02, 8'hA5);
				measure(4000 * (osc + 1));
				e = prev * 4000 * (osc + 1) / 256;
				check(1'(cnt >= e - 48 && cnt <= e + 48), 1'b1);
				i_host.wr(8'h49, 8'h00);
				measure(4000 * (osc + 1));
				e = int'(d) * 4000 * (osc + 1) / 256;
				check(1'(cnt >= e - 48 && cnt <= e + 48), 1'b1);
				prev = int'(d);
			end
		end
		i_host.wr(8'h00, 8'h03);
		i_host.wr(8'h01, 8'h00);
		i_host.wr(8'h02, 8'h02);
		i_host.wr(8'h49, 8'h00);
		measure(16000);
		check(1'(cnt >= 8000 - 48 && cnt <= 8000 + 48), 1'b1);
		$display("test pwm done");
		i_host.wr(8'h00, 8'h00);
		repeat (3) @(posedge clk);
		#1;
		check({chan_on, level}, 0);
		i_host.rd(8'h4A, rv);
		check(rv, sl);
		i_host.wr(8'h00, 8'h01);
		i_host.wr(8'h7F, 8'h01);
		i_host.rd(8'h6E, rv);
		check(rv, 8'hFF);
		i_host.wr(8'h7F, 8'h00);
		i_host.rd(8'h6E, rv);
		check(rv, 8'h00);
		i_host.rd(8'h4A, rv);
		check(rv, 8'h00);
		$display("test shutdown and soft reset done");
		print_verdict();
	end
endmodule : test_led_pwm_thermal_spread_ctrl
`default_nettype wire
